// File: dv/battery_domain_power_control_if_tb_top.sv
module battery_domain_power_control_if_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, bat_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [31:0] awa = 0, wd = 0, ara = 0, rdata, rd, r;
  logic [1:0] br, rr, rs, wk;
  logic [3:0] ws = 4'hF, cmd = 4'hB;
  logic aw_r, w_r, bv, ar_r, rv, pe, ov, pg;
  int fail_count = 0, num_checks = 0, seed = 54439;
  initial forever #2.5 clk = ~clk;
  bpc_board_model i_brd (.clk_i(clk), .cmd_i(cmd), .wake_n_o(wk), .ovrd_o(ov), .pg_o(pg));
  bpc_top i_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .BAT_RST_N_I(bat_n), .WAKE_INPUTS_N_I(wk),
    .OVERRIDE_INPUT_I(ov), .MAIN_POWER_GOOD_I(pg), .POWER_ENABLE_OUTPUT_O(pe), .AWADDR_I(awa),
    .AWVALID_I(awv), .AWREADY_O(aw_r), .WDATA_I(wd), .WSTRB_I(ws), .WVALID_I(wv), .WREADY_O(w_r),
    .BRESP_O(br), .BVALID_O(bv), .BREADY_I(bre), .ARADDR_I(ara), .ARVALID_I(arv), .ARREADY_O(ar_r),
    .RDATA_O(rdata), .RRESP_O(rr), .RVALID_O(rv), .RREADY_I(rre));
  task automatic chk(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // readies sampled mid-cycle: they only move on the rising edge
  task automatic xfer(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    int n;
    logic ka, kw, kd;
    @(posedge clk);
    if (w) {awa, wd, ws, awv, wv, bre} <= {a, d, s, 3'b111};
    else {ara, arv, rre} <= {a, 2'b11};
    for (n = 0; n < 100; n++) begin
      @(negedge clk);
      {ka, kw, kd} = w ? {aw_r, w_r, bv} : {ar_r, 1'b0, rv};
      {rd, rs} = {rdata, w ? br : rr};
      @(posedge clk);
      if (ka) {awv, arv} <= 2'b00;
      if (kw) wv <= 1'b0;
      if (kd) {bre, rre} <= 2'b00;
      if (kd) break;
    end
    if (n == 100) begin
      fail_count++;
      print_verdict;
    end
  endtask
  // c = {bypass, source, fw level}, p = {power good, override, wake pins}
  function automatic logic [31:0] exp_ctrl(input logic [2:0] c, input logic [3:0] p);
    logic o;
    o = (c[1] && p[3]) ? c[0] : (p[2] || !p[1] || !p[0]);
    return {19'h0, c, o, p[2], 6'h0, ~p[1:0]};
  endfunction
  task automatic step(input string nm, input logic [2:0] c, input logic [3:0] p);
    cmd <= p;
    r = $random(seed);
    xfer(1, 0, (r & 32'hFFFF_E0FF) | {c[2], 1'b0, c[0], 10'h0}, 4'hF);
    xfer(1, 0, (r & 32'hFFFF_E0FF) | {c, 10'h0}, 4'hF);
    repeat (40) @(posedge clk);
    xfer(0, 0, 0, 0);
    chk(nm, rd, exp_ctrl(c, p));
    $display("%s done", nm);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    {rst_n, bat_n} <= 2'b11;
    repeat (6) @(posedge clk);
    xfer(0, 0, 0, 0);
    chk("ctrl after reset", rd, exp_ctrl(3'b000, 4'hB));
    step("fw on", 3'b011, 4'hB);
    step("fw off with override", 3'b010, 4'hF);
    step("power lost", 3'b010, 4'h7);
    step("wake bypass", 3'b100, 4'h9);
    step("wake filtered", 3'b000, 4'hA);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      step("random", r[2:0], r[6:3]);
    end
    xfer(0, 32'hC, 0, 0);
    chk("unmapped resp", rs, 2'h2);
    step("bypass kept", 3'b111, 4'hB);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    xfer(1, 0, 32'h1C00, 4'hD);
    chk("write resp", rs, 2'h0);
    xfer(0, 0, 0, 0);
    chk("system reset", rd, exp_ctrl(3'b100, 4'hB));
    // invert wake 0, then latch it, drop the inversion and clear the latch
    xfer(1, 32'h4, 32'h1, 4'hF);
    xfer(1, 32'h8, 32'h1, 4'hF);
    xfer(0, 0, 0, 0);
    chk("polarity", rd, exp_ctrl(3'b100, 4'hB) | 32'h201);
    xfer(1, 32'h4, 0, 4'hF);
    xfer(0, 0, 0, 0);
    chk("latched wake", rd, exp_ctrl(3'b100, 4'hB) | 32'h1);
    xfer(1, 32'h8, 32'h1_0001, 4'hF);
    xfer(0, 0, 0, 0);
    chk("latch cleared", rd, exp_ctrl(3'b100, 4'hB));
    $display("polarity and latch done");
    print_verdict;
  end
endmodule

// File: dv/bpc_board_model.sv
module bpc_board_model (
  input logic clk_i,
  input logic [3:0] cmd_i,
  output logic [1:0] wake_n_o,
  output logic ovrd_o,
  output logic pg_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins idle: power good, no override, wakes released high
  initial {pg_o, ovrd_o, wake_n_o} = 4'hB;
  always @(posedge clk_i) {pg_o, ovrd_o, wake_n_o} <= cmd_i;
endmodule

// File: dv/bpc_checker.sv
module bpc_checker (
  input logic CLK_SYS_I, RST_N_I, POWER_ENABLE_OUTPUT_O, AWVALID_I, AWREADY_O, WREADY_O, BVALID_O,
  input logic BREADY_I, ARVALID_I, ARREADY_O, RVALID_O, WVALID_I,
  input logic [1:0] RRESP_O,
  input logic [31:0] ARADDR_I, RDATA_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ctl_q, bad_q;
  // ----------------------------------------
  // read address kind, held for the answer
  // ----------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (ARVALID_I && ARREADY_O) begin
      ctl_q <= ARADDR_I == 32'h0;
      bad_q <= !(ARADDR_I inside {32'h0, 32'h4, 32'h8});
    end
  end
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  out_reset_a: assert property ($rose(RST_N_I) |-> !POWER_ENABLE_OUTPUT_O)
    else $error("power enable high at reset release");
  rsvd_zero_a: assert property (RVALID_O && ctl_q |-> RDATA_O[31:13] == 0 && RDATA_O[7:2] == 0)
    else $error("reserved control bits not zero");
  out_status_a: assert property ($rose(RVALID_O) && ctl_q |-> RDATA_O[9] == $past(POWER_ENABLE_OUTPUT_O))
    else $error("output status differs from pin");
  unmapped_a: assert property (RVALID_O && bad_q |-> RRESP_O == 2'h2 && RDATA_O == 32'h0)
    else $error("unmapped read not refused");
  mapped_ok_a: assert property (RVALID_O && !bad_q |-> RRESP_O == 2'h0)
    else $error("mapped read refused");
  wr_resp_a: assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##[1:3] BVALID_O)
    else $error("write response missing");
  rd_resp_a: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
    else $error("read response late");
  ar_block_a: assert property (RVALID_O |-> !ARREADY_O)
    else $error("read address taken during answer");
  cover property (RVALID_O && ctl_q && RDATA_O[9]);
  cover property (RVALID_O && bad_q);
  cover property (BVALID_O && BREADY_I);
endmodule
bind bpc_top bpc_checker i_chk (.*);

// File: rtl/bpc_defs.vh
`ifndef BPC_DEFS_VH
`define BPC_DEFS_VH
// ----------------------------------------
// register map
// ----------------------------------------
`define BPC_ADDR_CTRL 32'h0000_0000
`define BPC_ADDR_POL 32'h0000_0004
`define BPC_ADDR_LATCH 32'h0000_0008
`define BPC_ADDR_MASK 32'h0000_000F
// ----------------------------------------
// field positions
// ----------------------------------------
`define BPC_BIT_BYPASS 12
`define BPC_BIT_SRC 11
`define BPC_BIT_FWLVL 10
`define BPC_BIT_OUT 9
`define BPC_BIT_OVRD 8
`define BPC_WAKE_MSB 1
`define BPC_NWAKE 2
`define BPC_CLR_MSB 17
`define BPC_CLR_LSB 16
// ----------------------------------------
// responses and counts
// ----------------------------------------
`define BPC_RESP_OKAY 2'h0
`define BPC_RESP_SLVERR 2'h2
`define BPC_FILT_W 4
`define BPC_FILT_MAX 4'hF
`endif

// File: rtl/bpc_top.v
// How it works
// - control bit 12 set bypasses wake input filters; cleared by battery reset or a firmware write of 0, not by system reset
// - bit 11 picks firmware bit or wake inputs ORed with override input to drive power enable
// - bit 10 sets power enable level when firmware source and main power good
// - read-only bit 9 shows power enable output level
// - read-only bit 8 shows override input level
// - bits 1:0 show latched or live wake inputs after polarity
// - status bits follow pins and output logic after reset, not constants
`include "bpc_defs.vh"
module bpc_top (
  // clock and resets
  input wire CLK_SYS_I,
  input wire RST_N_I,
  input wire BAT_RST_N_I,
  // pins
  input wire [1:0] WAKE_INPUTS_N_I,
  input wire OVERRIDE_INPUT_I,
  input wire MAIN_POWER_GOOD_I,
  output reg POWER_ENABLE_OUTPUT_O,
  // axi4-lite write
  input wire [31:0] AWADDR_I,
  input wire AWVALID_I,
  output wire AWREADY_O,
  input wire [31:0] WDATA_I,
  input wire [3:0] WSTRB_I,
  input wire WVALID_I,
  output wire WREADY_O,
  output reg [1:0] BRESP_O,
  output reg BVALID_O,
  input wire BREADY_I,
  // axi4-lite read
  input wire [31:0] ARADDR_I,
  input wire ARVALID_I,
  output wire ARREADY_O,
  output reg [31:0] RDATA_O,
  output reg [1:0] RRESP_O,
  output reg RVALID_O,
  input wire RREADY_I
);
  // ----------------------------------------
  // pin synchronisers, three stages
  // ----------------------------------------
  reg [1:0] wk_s1_q, wk_s2_q, wk_s3_q;
  reg [2:0] pin_s1_q, pin_s2_q, pin_s3_q;
  always @(posedge CLK_SYS_I) begin
    wk_s1_q <= WAKE_INPUTS_N_I;
    wk_s2_q <= wk_s1_q;
    wk_s3_q <= wk_s2_q;
    pin_s1_q <= {MAIN_POWER_GOOD_I, OVERRIDE_INPUT_I, 1'b0};
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg bypass_q;
  reg src_sel_q;
  reg fw_level_q;
  reg [1:0] pol_q;
  reg [1:0] latch_en_q;
  reg [1:0] wake_latched_q;
  reg ovrd_q;
  reg pg_q;
  wire [1:0] wake_live;
  // ----------------------------------------
  // wake input filters, one per input
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `BPC_NWAKE; g = g + 1) begin : g_wake
      reg [`BPC_FILT_W-1:0] cnt_q;
      reg filt_q;
      wire agree = (wk_s2_q[g] == wk_s3_q[g]);
      wire differs = (wk_s3_q[g] != filt_q);
      always @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
          cnt_q <= {`BPC_FILT_W{1'b0}};
          filt_q <= wk_s3_q[g];
        end else if (bypass_q) begin
          cnt_q <= {`BPC_FILT_W{1'b0}};
          if (agree) filt_q <= wk_s3_q[g];
        end else if (!agree || !differs) begin
          cnt_q <= {`BPC_FILT_W{1'b0}};
        end else if (cnt_q == `BPC_FILT_MAX) begin
          cnt_q <= {`BPC_FILT_W{1'b0}};
          filt_q <= wk_s3_q[g];
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
      // active-low pin asserted reads as 1, then polarity inversion
      assign wake_live[g] = (~filt_q) ^ pol_q[g];
    end
  endgenerate
  // ----------------------------------------
  // output logic and status capture
  // ----------------------------------------
  wire pe_d = (src_sel_q && pg_q) ? fw_level_q : (|wake_live | ovrd_q);
  wire [1:0] wake_view = (latch_en_q & wake_latched_q) | (~latch_en_q & wake_live);
  always @(posedge CLK_SYS_I) begin
    if (pin_s2_q[1] == pin_s3_q[1]) ovrd_q <= pin_s3_q[1];
    if (pin_s2_q[2] == pin_s3_q[2]) pg_q <= pin_s3_q[2];
  end
  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) POWER_ENABLE_OUTPUT_O <= 1'b0;
    else POWER_ENABLE_OUTPUT_O <= pe_d;
  end
  // ----------------------------------------
  // axi4-lite slave, single outstanding
  // ----------------------------------------
  reg aw_q, w_q;
  reg [31:0] awaddr_q, wdata_q;
  assign AWREADY_O = !aw_q && !BVALID_O;
  assign WREADY_O = !w_q && !BVALID_O;
  assign ARREADY_O = !RVALID_O;
  wire wr_go = aw_q && w_q && !BVALID_O;
  reg wstrb1_q;
  wire wr_ctrl = wr_go && awaddr_q == `BPC_ADDR_CTRL;
  wire ctrl_hit = wr_go && (awaddr_q & ~`BPC_ADDR_MASK) == `BPC_ADDR_CTRL;
  // byte lane 1 holds bits 12:8
  wire wr_b1 = wr_go && awaddr_q == `BPC_ADDR_CTRL && wstrb1_q;
  reg [1:0] wstrb0_q;
  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb1_q <= 1'b0;
      wstrb0_q <= 2'h0;
      BVALID_O <= 1'b0;
      BRESP_O <= `BPC_RESP_OKAY;
    end else begin
      if (AWVALID_I && AWREADY_O) begin
        aw_q <= 1'b1;
        awaddr_q <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
        w_q <= 1'b1;
        wdata_q <= WDATA_I;
        wstrb1_q <= WSTRB_I[1];
        wstrb0_q <= {1'b0, WSTRB_I[0]};
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        BVALID_O <= 1'b1;
        BRESP_O <= (awaddr_q == `BPC_ADDR_CTRL || awaddr_q == `BPC_ADDR_POL ||
                    awaddr_q == `BPC_ADDR_LATCH) ? `BPC_RESP_OKAY : `BPC_RESP_SLVERR;
      end else if (BVALID_O && BREADY_I) begin
        BVALID_O <= 1'b0;
      end
    end
  end
  // firmware-facing bits on system reset
  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I || !BAT_RST_N_I) begin
      src_sel_q <= 1'b0;
      fw_level_q <= 1'b0;
    end else if (wr_b1) begin
      src_sel_q <= wdata_q[`BPC_BIT_SRC];
      fw_level_q <= wdata_q[`BPC_BIT_FWLVL];
    end
  end
  // bypass survives system reset, cleared by battery reset or a firmware write of 0
  always @(posedge CLK_SYS_I) begin
    if (!BAT_RST_N_I) bypass_q <= 1'b0;
    else if (wr_b1) bypass_q <= wdata_q[`BPC_BIT_BYPASS];
  end
  // polarity and latch enable live in the battery domain too
  always @(posedge CLK_SYS_I) begin
    if (!BAT_RST_N_I) begin
      pol_q <= 2'h0;
      latch_en_q <= 2'h0;
    end else if (wr_go && wstrb0_q[0]) begin
      if (awaddr_q == `BPC_ADDR_POL) pol_q <= wdata_q[`BPC_WAKE_MSB:0];
      if (awaddr_q == `BPC_ADDR_LATCH) latch_en_q <= wdata_q[`BPC_WAKE_MSB:0];
    end
  end
  // latches catch asserted wake; writing 1 to latch register bit 16 or 17 clears, set wins
  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) wake_latched_q <= 2'h0;
    else wake_latched_q <= (wake_latched_q &
      ~((wr_go && wstrb0_q[0] && awaddr_q == `BPC_ADDR_LATCH) ? wdata_q[`BPC_CLR_MSB:`BPC_CLR_LSB] : 2'h0)) |
      wake_live;
  end
  // ----------------------------------------
  // read channel
  // ----------------------------------------
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    case (ARADDR_I)
      `BPC_ADDR_CTRL: begin
        rd_d[`BPC_BIT_BYPASS] = bypass_q;
        rd_d[`BPC_BIT_SRC] = src_sel_q;
        rd_d[`BPC_BIT_FWLVL] = fw_level_q;
        rd_d[`BPC_BIT_OUT] = POWER_ENABLE_OUTPUT_O;
        rd_d[`BPC_BIT_OVRD] = ovrd_q;
        rd_d[`BPC_WAKE_MSB:0] = wake_view;
      end
      `BPC_ADDR_POL: rd_d[`BPC_WAKE_MSB:0] = pol_q;
      `BPC_ADDR_LATCH: rd_d[`BPC_WAKE_MSB:0] = latch_en_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end
  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h0000_0000;
      RRESP_O <= `BPC_RESP_OKAY;
    end else if (ARVALID_I && ARREADY_O) begin
      RVALID_O <= 1'b1;
      RDATA_O <= rd_d;
      RRESP_O <= (ARADDR_I == `BPC_ADDR_CTRL || ARADDR_I == `BPC_ADDR_POL ||
                  ARADDR_I == `BPC_ADDR_LATCH) ? `BPC_RESP_OKAY : `BPC_RESP_SLVERR;
    end else if (RVALID_O && RREADY_I) begin
      RVALID_O <= 1'b0;
    end
  end
  wire unused_ok = wr_ctrl | ctrl_hit | wstrb0_q[1] | pin_s3_q[0];
endmodule
